// ### occr_regs.sv
// Behaviour
// - Command word: code in bits 15..8, data in bits 7..0.
// - Code 00h sets 3-bit clock divide select, 1/1 to 1/128, reset 1/1.
// - Code 01h stores 7-bit adjust value A, reset zero.
// - Source A bit: 0 selects OTP A value, 1 selects register A.
// - Code 02h stores 7-bit adjust value B, reset zero.
// - Source B bit: 0 selects OTP B value, 1 selects register B.
// - Code 03h bit 0 enables step-up converter; disabled after reset.
// - Loop tracking bit: 0 tracks forward voltage pad, 1 internal bandgap.
// - Two-bit converter frequency: 150, 200, 250, 300 kHz; reset 150.
// - Code 06h loads 3-bit voltage offset code, reset zero.
// - Display off stops scanning, grounds outputs; converter follows own enable.
// - Display on with all-lit set lights every pixel.
// - Reverse bit inverts pixel data read from display RAM.
// - Horizontal mirror reorders columns as data is written to RAM.
// - Vertical mirror flips displayed image vertically.
// - Dummy-line field gives one, two, four or eight dummy lines.
// - Code 12h loads scan line select, n selects line n+1, reset 47h.
// - Dimmer change waits for vertical sync when on, immediate when off.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module occr_regs (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Command port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// Clock divider
	output logic      [2:0] clock_divide_select,
	output logic            sclk_tick,
	// Brightness adjustment
	output logic      [6:0] adjust_value_a,
	output logic            adjust_source_a,
	output logic      [6:0] adjust_value_b,
	output logic            adjust_source_b,
	// Converter
	output logic            converter_enable,
	output logic            loop_tracking_select,
	output logic      [1:0] converter_frequency,
	output logic      [2:0] voltage_offset_code,
	// Display control
	output logic            display_on,
	output logic            all_pixels_lit,
	output logic            display_reverse,
	output logic            scan_enable,
	output logic            outputs_low_ground,
	// Direction and scan
	output logic            horizontal_mirror,
	output logic            vertical_mirror,
	output logic      [1:0] dummy_line_count,
	output logic      [3:0] dummy_lines,
	output logic      [6:0] scan_line_select,
	// Pixel paths
	input  wire logic       ram_pixel,
	output logic            pixel_out,
	input  wire logic [7:0] write_column,
	output logic      [7:0] ram_column,
	input  wire logic [6:0] scan_row,
	output logic      [6:0] display_row,
	// Dimmer timing
	input  wire logic       dimmer_request,
	input  wire logic       vertical_sync_input,
	output logic            dimmer_apply
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] div;
		logic [6:0] adj_a;
		logic       src_a;
		logic [6:0] adj_b;
		logic       src_b;
		logic       conv_en;
		logic       track;
		logic [1:0] freq;
		logic [2:0] voff;
		logic       disp_on;
		logic       all_lit;
		logic       rev;
		logic       hmir;
		logic       vmir;
		logic [1:0] dummy;
		logic [6:0] scan;
		logic [7:0] rdata;
		logic [6:0] div_cnt;
		logic       tick;
		logic       vs_meta;
		logic       vs_sync;
		logic       vs_prev;
		logic       dim_pend;
		logic       dim_apply;
		logic       pix;
		logic [7:0] col;
		logic [6:0] row;
	} occr_state_t;

	occr_state_t st_r;
	occr_state_t st_nxt;
	logic [15:0] cmd_word;
	logic        vs_rise;
	logic        dim_want;

	function automatic logic [7:0] readback(input occr_state_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			occr_pkg::OFF_CLOCK_DIVIDER: v = {5'h00, s.div};
			occr_pkg::OFF_BRIGHT_A:      v = {s.src_a, s.adj_a};
			occr_pkg::OFF_BRIGHT_B:      v = {s.src_b, s.adj_b};
			occr_pkg::OFF_BOOST_CTRL:    v = {4'h0, s.freq, s.track, s.conv_en};
			occr_pkg::OFF_BOOST_OFFSET:  v = {5'h00, s.voff};
			occr_pkg::OFF_DISPLAY_CTRL:  v = {5'h00, s.rev, s.all_lit, s.disp_on};
			occr_pkg::OFF_DISPLAY_DIR:   v = {2'h0, s.dummy, 2'h0, s.vmir, s.hmir};
			occr_pkg::OFF_SCAN_LINES:    v = {1'b0, s.scan};
			occr_pkg::OFF_STATUS: begin
				v[occr_pkg::STAT_SCAN_BIT] = s.disp_on;
				v[occr_pkg::STAT_GND_BIT]  = ~s.disp_on;
				v[occr_pkg::STAT_DIM_BIT]  = s.dim_pend;
				v[occr_pkg::STAT_CONV_BIT] = s.conv_en;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction : readback

	// Write command codes that this bank answers to
	function automatic logic is_command(input logic [7:0] code);
		return code inside {occr_pkg::OFF_CLOCK_DIVIDER, occr_pkg::OFF_BRIGHT_A, occr_pkg::OFF_BRIGHT_B,
			occr_pkg::OFF_BOOST_CTRL, occr_pkg::OFF_BOOST_OFFSET, occr_pkg::OFF_DISPLAY_CTRL,
			occr_pkg::OFF_DISPLAY_DIR, occr_pkg::OFF_SCAN_LINES};
	endfunction : is_command

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt   = st_r;
		cmd_word = {addr, wdata};
		if (wr) begin
			unique case (cmd_word[15:8])
				occr_pkg::OFF_CLOCK_DIVIDER: st_nxt.div = cmd_word[2:0];
				occr_pkg::OFF_BRIGHT_A: begin
					st_nxt.adj_a = cmd_word[6:0];
					st_nxt.src_a = cmd_word[occr_pkg::BRIGHT_SRC_BIT];
				end
				occr_pkg::OFF_BRIGHT_B: begin
					st_nxt.adj_b = cmd_word[6:0];
					st_nxt.src_b = cmd_word[occr_pkg::BRIGHT_SRC_BIT];
				end
				occr_pkg::OFF_BOOST_CTRL: begin
					st_nxt.conv_en = cmd_word[occr_pkg::CONV_EN_BIT];
					st_nxt.track   = cmd_word[occr_pkg::CONV_TRACK_BIT];
					st_nxt.freq    = cmd_word[occr_pkg::CONV_FREQ_LSB +: 2];
				end
				occr_pkg::OFF_BOOST_OFFSET: st_nxt.voff = cmd_word[2:0];
				occr_pkg::OFF_DISPLAY_CTRL: begin
					st_nxt.disp_on = cmd_word[occr_pkg::DISP_ON_BIT];
					st_nxt.all_lit = cmd_word[occr_pkg::DISP_ALL_BIT];
					st_nxt.rev     = cmd_word[occr_pkg::DISP_REV_BIT];
				end
				occr_pkg::OFF_DISPLAY_DIR: begin
					st_nxt.hmir  = cmd_word[occr_pkg::DIR_HMIR_BIT];
					st_nxt.vmir  = cmd_word[occr_pkg::DIR_VMIR_BIT];
					st_nxt.dummy = cmd_word[occr_pkg::DIR_DUMMY_LSB +: 2];
				end
				occr_pkg::OFF_SCAN_LINES: st_nxt.scan = cmd_word[6:0];
				default: st_nxt.div = st_r.div;
			endcase
		end
		// Read data stand only in the cycle after the strobe
		st_nxt.rdata = rd ? readback(st_r, addr) : 8'h00;

		// Divided clock tick: low div bits all ones
		st_nxt.div_cnt = st_r.div_cnt + 7'h01;
		st_nxt.tick    = ((st_r.div_cnt & 7'((8'h01 << st_r.div) - 8'h01))
			== 7'((8'h01 << st_r.div) - 8'h01));

		// Vertical sync synchroniser and edge
		st_nxt.vs_meta = vertical_sync_input;
		st_nxt.vs_sync = st_r.vs_meta;
		st_nxt.vs_prev = st_r.vs_sync;
		vs_rise        = st_r.vs_sync & ~st_r.vs_prev;
		dim_want       = st_r.dim_pend | dimmer_request;
		st_nxt.dim_apply = st_r.disp_on ? (dim_want & vs_rise) : dim_want;
		st_nxt.dim_pend  = st_r.disp_on & dim_want & ~vs_rise;

		// Pixel path: off grounds, all-lit overrides, reverse inverts
		if (!st_r.disp_on)
			st_nxt.pix = 1'b0;
		else if (st_r.all_lit)
			st_nxt.pix = 1'b1;
		else
			st_nxt.pix = ram_pixel ^ st_r.rev;

		st_nxt.col = st_r.hmir ? ~write_column : write_column;
		st_nxt.row = st_r.vmir ? 7'(st_r.scan - scan_row) : scan_row;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r       <= '0;
			st_r.div   <= occr_pkg::RST_CLOCK_DIV;
			st_r.adj_a <= occr_pkg::RST_ADJUST;
			st_r.adj_b <= occr_pkg::RST_ADJUST;
			st_r.freq  <= occr_pkg::RST_CONV_FREQ;
			st_r.voff  <= occr_pkg::RST_VOLT_OFFSET;
			st_r.dummy <= occr_pkg::RST_DUMMY;
			st_r.scan  <= occr_pkg::RST_SCAN_LINES;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata                = st_r.rdata;
	assign clock_divide_select  = st_r.div;
	assign sclk_tick            = st_r.tick;
	assign adjust_value_a       = st_r.adj_a;
	assign adjust_source_a      = st_r.src_a;
	assign adjust_value_b       = st_r.adj_b;
	assign adjust_source_b      = st_r.src_b;
	assign converter_enable     = st_r.conv_en;
	assign loop_tracking_select = st_r.track;
	assign converter_frequency  = st_r.freq;
	assign voltage_offset_code  = st_r.voff;
	assign display_on           = st_r.disp_on;
	assign all_pixels_lit       = st_r.all_lit;
	assign display_reverse      = st_r.rev;
	assign scan_enable          = st_r.disp_on;
	assign outputs_low_ground   = ~st_r.disp_on;
	assign horizontal_mirror    = st_r.hmir;
	assign vertical_mirror      = st_r.vmir;
	assign dummy_line_count     = st_r.dummy;
	assign dummy_lines          = 4'(5'h01 << st_r.dummy);
	assign scan_line_select     = st_r.scan;
	assign pixel_out            = st_r.pix;
	assign ram_column           = st_r.col;
	assign display_row          = st_r.row;
	assign dimmer_apply         = st_r.dim_apply;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_scan_write: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_SCAN_LINES |=> scan_line_select == $past(wdata[6:0]))
		else $error("scan line select not loaded");

	a_undefined_keep: assert property (@(posedge clk) disable iff (rst)
		wr && !is_command(addr) |=> $stable({clock_divide_select, adjust_source_a, adjust_value_a,
			adjust_source_b, adjust_value_b, converter_enable, loop_tracking_select, converter_frequency,
			voltage_offset_code, display_on, all_pixels_lit, display_reverse, horizontal_mirror,
			vertical_mirror, dummy_line_count, scan_line_select}))
		else $error("undefined code changed a register");

	a_conv_enable: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_BOOST_CTRL |=> converter_enable == $past(wdata[0])
			&& converter_frequency == $past(wdata[3:2]))
		else $error("converter control not loaded");

	a_div_one: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) && $past(clock_divide_select) == 3'h0 |-> sclk_tick)
		else $error("divide by one missed a tick");

	a_off_ground: assert property (@(posedge clk) disable iff (rst)
		!display_on |=> !pixel_out)
		else $error("pixel driven while display off");

	a_all_lit: assert property (@(posedge clk) disable iff (rst)
		display_on && all_pixels_lit |=> pixel_out)
		else $error("all-lit pixel not lit");

	a_reverse_pix: assert property (@(posedge clk) disable iff (rst)
		display_on && !all_pixels_lit && display_reverse |=> pixel_out == !$past(ram_pixel))
		else $error("reverse not applied");

	a_hmirror_col: assert property (@(posedge clk) disable iff (rst)
		horizontal_mirror |=> ram_column == ~$past(write_column))
		else $error("column not mirrored");

	a_dimmer_off: assert property (@(posedge clk) disable iff (rst)
		!display_on && dimmer_request ##1 !dimmer_request |-> dimmer_apply ##1 !dimmer_apply)
		else $error("dimmer not applied at once while off");

	a_div_write: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_CLOCK_DIVIDER |=> clock_divide_select == $past(wdata[2:0]))
		else $error("divide select not loaded");

	a_div_hold: assert property (@(posedge clk) disable iff (rst)
		!(wr && addr == occr_pkg::OFF_CLOCK_DIVIDER) |=> $stable(clock_divide_select))
		else $error("divide select changed without its command");

	a_tick_gap: assert property (@(posedge clk) disable iff (rst)
		sclk_tick && clock_divide_select == 3'h1 && $past(clock_divide_select) == 3'h1
			|=> !sclk_tick)
		else $error("divide by two ticked twice in a row");

	a_adjust_a: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_BRIGHT_A |=> {adjust_source_a, adjust_value_a} == $past(wdata))
		else $error("adjust A not loaded");

	a_adjust_b: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_BRIGHT_B |=> {adjust_source_b, adjust_value_b} == $past(wdata))
		else $error("adjust B not loaded");

	a_track_load: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_BOOST_CTRL |=> loop_tracking_select == $past(wdata[1]))
		else $error("loop tracking select not loaded");

	a_offset_load: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_BOOST_OFFSET |=> voltage_offset_code == $past(wdata[2:0]))
		else $error("voltage offset not loaded");

	a_disp_load: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_DISPLAY_CTRL
			|=> {display_reverse, all_pixels_lit, display_on} == $past(wdata[2:0]))
		else $error("display control not loaded");

	a_off_conv: assert property (@(posedge clk) disable iff (rst)
		$changed(display_on) |-> $stable(converter_enable))
		else $error("converter moved with display on bit");

	a_ground_idle: assert property (@(posedge clk) disable iff (rst)
		!display_on |-> outputs_low_ground && !scan_enable)
		else $error("scanning while display off");

	a_plain_pix: assert property (@(posedge clk) disable iff (rst)
		display_on && !all_pixels_lit && !display_reverse |=> pixel_out == $past(ram_pixel))
		else $error("pixel altered without reverse");

	a_dir_load: assert property (@(posedge clk) disable iff (rst)
		wr && addr == occr_pkg::OFF_DISPLAY_DIR |=> {dummy_line_count, vertical_mirror, horizontal_mirror}
			== {$past(wdata[5:4]), $past(wdata[1:0])})
		else $error("direction not loaded");

	a_plain_col: assert property (@(posedge clk) disable iff (rst)
		!horizontal_mirror |=> ram_column == $past(write_column))
		else $error("column altered without mirror");

	a_vmirror_row: assert property (@(posedge clk) disable iff (rst)
		vertical_mirror |=> display_row == 7'($past(scan_line_select) - $past(scan_row)))
		else $error("row not flipped");

	a_plain_row: assert property (@(posedge clk) disable iff (rst)
		!vertical_mirror |=> display_row == $past(scan_row))
		else $error("row altered without mirror");

	a_dummy_decode: assert property (@(posedge clk) disable iff (rst)
		dummy_lines == ((dummy_line_count == 2'h0) ? 4'h1 : (dummy_line_count == 2'h1) ? 4'h2
			: (dummy_line_count == 2'h2) ? 4'h4 : 4'h8))
		else $error("dummy line decode wrong");

	a_scan_hold: assert property (@(posedge clk) disable iff (rst)
		!(wr && addr == occr_pkg::OFF_SCAN_LINES) |=> $stable(scan_line_select))
		else $error("scan line select changed without its command");

	a_dimmer_hold: assert property (@(posedge clk) disable iff (rst)
		display_on && dimmer_request && !vs_rise |=> !dimmer_apply)
		else $error("dimmer applied before vertical sync");

	a_dimmer_sync: assert property (@(posedge clk) disable iff (rst)
		display_on && (st_r.dim_pend || dimmer_request) && vs_rise |=> dimmer_apply)
		else $error("dimmer not applied at vertical sync");

	a_sync_two: assert property (@(posedge clk) disable iff (rst)
		vs_rise |-> $past(vertical_sync_input, 2))
		else $error("sync edge without pin rise");

	a_status_dim: assert property (@(posedge clk) disable iff (rst)
		rd && addr == occr_pkg::OFF_STATUS |=> rdata[occr_pkg::STAT_DIM_BIT] == $past(st_r.dim_pend))
		else $error("status pending bit wrong");

	a_read_idle: assert property (@(posedge clk) disable iff (rst)
		!rd |=> rdata == 8'h00)
		else $error("read data without read strobe");

endmodule : occr_regs

// ### occr_pkg.sv
package occr_pkg;

	// ----------------------------------------------------------------
	// Command codes (register offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CLOCK_DIVIDER  = 8'h00;
	localparam logic [7:0] OFF_BRIGHT_A       = 8'h01;
	localparam logic [7:0] OFF_BRIGHT_B       = 8'h02;
	localparam logic [7:0] OFF_BOOST_CTRL     = 8'h03;
	localparam logic [7:0] OFF_BOOST_OFFSET   = 8'h06;
	localparam logic [7:0] OFF_DISPLAY_CTRL   = 8'h10;
	localparam logic [7:0] OFF_DISPLAY_DIR    = 8'h11;
	localparam logic [7:0] OFF_SCAN_LINES     = 8'h12;
	localparam logic [7:0] OFF_STATUS         = 8'h40;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BRIGHT_SRC_BIT  = 7;
	localparam int CONV_EN_BIT     = 0;
	localparam int CONV_TRACK_BIT  = 1;
	localparam int CONV_FREQ_LSB   = 2;
	localparam int DISP_ON_BIT     = 0;
	localparam int DISP_ALL_BIT    = 1;
	localparam int DISP_REV_BIT    = 2;
	localparam int DIR_HMIR_BIT    = 0;
	localparam int DIR_VMIR_BIT    = 1;
	localparam int DIR_DUMMY_LSB   = 4;
	localparam int STAT_SCAN_BIT   = 0;
	localparam int STAT_GND_BIT    = 1;
	localparam int STAT_DIM_BIT    = 2;
	localparam int STAT_CONV_BIT   = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] RST_CLOCK_DIV   = 3'h0;
	localparam logic [6:0] RST_ADJUST      = 7'h00;
	localparam logic [1:0] RST_CONV_FREQ   = 2'h0;
	localparam logic [2:0] RST_VOLT_OFFSET = 3'h0;
	localparam logic [1:0] RST_DUMMY       = 2'h0;
	localparam logic [6:0] RST_SCAN_LINES  = 7'h47;

endpackage : occr_pkg

// ### occr_host.sv
`timescale 1ns/1ps
module occr_host (
	// Clock
	input  wire logic       clk,
	// Command port to the device
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// ----------------------------------------------------------------
	// Command word, entered right after a rising edge
	// ----------------------------------------------------------------
	task automatic send(input logic [15:0] word, input logic is_rd);
		addr  <= word[15:8];
		wdata <= is_rd ? 8'h00 : word[7:0];
		wr    <= !is_rd;
		rd    <= is_rd;
		@(posedge clk);
	endtask : send

	// Strobes low until the next command
	task automatic idle();
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : idle
endmodule : occr_host

// ### tb_occr_regs.sv
`timescale 1ns/1ps
module tb_occr_regs;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr, wdata, rdata, write_column, ram_column;
	logic [6:0] adjust_value_a, adjust_value_b, scan_line_select, scan_row, display_row;
	logic [2:0] clock_divide_select, voltage_offset_code;
	logic [1:0] converter_frequency, dummy_line_count;
	logic [3:0] dummy_lines;
	logic       wr, rd, adjust_source_a, adjust_source_b, converter_enable, loop_tracking_select;
	logic       display_on, all_pixels_lit, display_reverse, scan_enable, outputs_low_ground;
	logic       horizontal_mirror, vertical_mirror, ram_pixel, pixel_out;
	logic       dimmer_request, vertical_sync_input, dimmer_apply, sclk_tick;
	int         num_errors = 0;
	int         checks = 0;
	int         seed = 705;
	logic [7:0] m [0:18];
	logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h10, 8'h11, 8'h12};
	logic [7:0] masks [8] = '{8'h07, 8'hff, 8'hff, 8'h0f, 8'h07, 8'h07, 8'h33, 8'h7f};

	always #2 clk = ~clk;

	occr_host host (.clk, .addr, .wdata, .wr, .rd);

	occr_regs uut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .clock_divide_select, .sclk_tick,
		.adjust_value_a, .adjust_source_a, .adjust_value_b, .adjust_source_b, .converter_enable,
		.loop_tracking_select, .converter_frequency, .voltage_offset_code, .display_on, .all_pixels_lit,
		.display_reverse, .scan_enable, .outputs_low_ground, .horizontal_mirror, .vertical_mirror,
		.dummy_line_count, .dummy_lines, .scan_line_select, .ram_pixel, .pixel_out, .write_column,
		.ram_column, .scan_row, .display_row, .dimmer_request, .vertical_sync_input, .dimmer_apply);

	// ----------------------------------------------------------------
	// Comparison and model
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic check_all(input logic px, input logic [7:0] col, input logic [6:0] row);
		logic on;
		on = m[16][0];
		chk(8'(clock_divide_select), m[0]);
		chk({adjust_source_a, adjust_value_a}, m[1]);
		chk({adjust_source_b, adjust_value_b}, m[2]);
		chk(8'({converter_frequency, loop_tracking_select, converter_enable}), m[3]);
		chk(8'(voltage_offset_code), m[6]);
		chk(8'({display_reverse, all_pixels_lit, display_on}), m[16]);
		chk(8'({scan_enable, outputs_low_ground}), 8'({on, !on}));
		chk({2'h0, dummy_line_count, 2'h0, vertical_mirror, horizontal_mirror}, m[17]);
		chk(8'(dummy_lines), 8'h01 << m[17][5:4]);
		chk(8'(scan_line_select), m[18]);
		chk({7'h00, pixel_out}, {7'h00, on & (m[16][1] | (px ^ m[16][2]))});
		chk(ram_column, m[17][0] ? ~col : col);
		chk({1'b0, display_row}, {1'b0, m[17][1] ? m[18][6:0] - row : row});
	endtask : check_all

	// Fresh pixel inputs, one edge, then compare every register and pixel path output
	task automatic cycle_paths();
		logic       px;
		logic [7:0] col;
		logic [6:0] row;
		px = 1'($random(seed));
		col = 8'($random(seed));
		row = 7'($random(seed));
		host.idle();
		ram_pixel <= px;
		write_column <= col;
		scan_row <= row;
		@(posedge clk);
		#1 check_all(px, col, row);
		@(posedge clk);
	endtask : cycle_paths

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int         k, hits;
		logic [7:0] d, c;
		ram_pixel = 1'b0;
		write_column = 8'h00;
		scan_row = 7'h00;
		dimmer_request = 1'b0;
		vertical_sync_input = 1'b0;
		for (int i = 0; i < 19; i++) m[i] = 8'h00;
		m[18] = 8'h47;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		cycle_paths();
		$display("reset values test done");
		for (int n = 0; n < 300; n++) begin
			k = $unsigned($random(seed)) % 8;
			d = 8'($random(seed)) & masks[k];
			if (codes[k] == 8'h12) d = d % 8'h48;
			host.send({codes[k], d}, 1'b0);
			m[codes[k]] = d;
			cycle_paths();
		end
		$display("random command test done");
		for (int n = 0; n < 8; n++) begin
			host.send({8'h00, 8'(n)}, 1'b0);
			m[0] = 8'(n);
			host.idle();
			@(posedge clk);
			hits = 0;
			repeat (128) begin
				@(posedge clk);
				#1 if (sclk_tick === 1'b1) hits++;
			end
			chk(8'(hits), 8'(128 >> n));
			@(posedge clk);
		end
		$display("divider tick test done");
		for (int n = 0; n < 60; n++) begin
			c = 8'($random(seed));
			if (!(c inside {codes})) host.send({c, 8'($random(seed))}, 1'b0);
			cycle_paths();
		end
		$display("undefined code test done");
		for (int j = 0; j < 9; j++) begin
			c = (j < 8) ? codes[j] : 8'h05;
			host.send({c, 8'h00}, 1'b1);
			host.idle();
			#1 chk(rdata, m[c]);
			@(posedge clk);
		end
		$display("readback test done");
		host.send(16'h1000, 1'b0);
		m[16] = 8'h00;
		host.idle();
		dimmer_request <= 1'b1;
		@(posedge clk);
		dimmer_request <= 1'b0;
		#1 chk(8'(dimmer_apply), 8'h01);
		@(posedge clk);
		host.send(16'h1001, 1'b0);
		m[16] = 8'h01;
		host.idle();
		dimmer_request <= 1'b1;
		@(posedge clk);
		dimmer_request <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(8'(dimmer_apply), 8'h00);
		@(posedge clk);
		host.send(16'h4000, 1'b1);
		host.idle();
		#1 chk(rdata, {4'h0, m[3][0], 1'b1, 1'b0, 1'b1});
		@(posedge clk);
		vertical_sync_input <= 1'b1;
		hits = 0;
		repeat (6) begin
			@(posedge clk);
			#1 if (dimmer_apply === 1'b1) hits++;
		end
		chk(8'(hits), 8'h01);
		$display("dimmer timing test done");
		give_verdict();
	end
endmodule : tb_occr_regs
